// ===== hw/sef_defs.svh
`ifndef SEF_DEFS_SVH
`define SEF_DEFS_SVH

// Register byte addresses on the register bus
`define SEF_ADDR_CONFIG    8'h00
`define SEF_ADDR_IRQ_EN_LO 8'h04
`define SEF_ADDR_IRQ_EN_HI 8'h08
`define SEF_ADDR_WETTING   8'h0c
`define SEF_ADDR_INT_STAT  8'h10
`define SEF_ADDR_SW_STAT   8'h14
`define SEF_ADDR_MISC_STAT 8'h18

// Configuration register fields
`define SEF_CFG_RUN        0
`define SEF_CFG_FILT_LSB   1
`define SEF_CFG_SRC_DIS    3
`define SEF_CFG_SNK_DIS    4
`define SEF_CFG_MASK       32'h0000_001f

// Wetting register fields (3-bit codes)
`define SEF_WET_SRC_LSB    0
`define SEF_WET_SNK_LSB    3
`define SEF_WET_MASK       32'h0000_003f

// Interrupt status bits
`define SEF_IST_SSC        0
`define SEF_IST_WARN       1
`define SEF_IST_SHUT       2
`define SEF_IST_PAR        3

// Serial word layout
`define SEF_SPI_BITS       6'h21
`define SEF_SPI_ADDR_HI    30
`define SEF_SPI_ADDR_LO    24
`define SEF_SPI_WRITE      31
`define SEF_SPI_IST_ADDR   7'h04

// Reset value and input count
`define SEF_RST_REG        32'h0000_0000
`define SEF_NUM_IN         24

`endif

// ===== hw/sef_pkg.sv
package sef_pkg;

  // Wetting current settings
  typedef enum logic [2:0] {
    SEF_WET_0MA  = 3'h0,
    SEF_WET_1MA  = 3'h1,
    SEF_WET_2MA  = 3'h2,
    SEF_WET_5MA  = 3'h3,
    SEF_WET_10MA = 3'h4,
    SEF_WET_15MA = 3'h5
  } sef_wet_type;

  // Per-input interrupt condition
  typedef enum logic [1:0] {
    SEF_EDGE_OFF  = 2'h0,
    SEF_EDGE_RISE = 2'h1,
    SEF_EDGE_FALL = 2'h2,
    SEF_EDGE_BOTH = 2'h3
  } sef_edge_type;

endpackage

// ===== hw/sef_event_flags.sv
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "sef_defs.svh"
module sef_event_flags
  import sef_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Comparator results and detection strobe
  input  wire logic [23:0] i_comp_above,
  input  wire logic        i_cycle_done,
  // Temperature indications
  input  wire logic        i_warn_level,
  input  wire logic        i_shut_level,
  // Serial link pins
  input  wire logic        i_sclk,
  input  wire logic        i_cs_b,
  input  wire logic        i_mosi,
  output logic             o_miso,
  // Interrupt pin, open drain, active low
  output logic             o_int_b_out,
  output logic             o_int_b_oe,
  // Wetting current drive and scan restart
  output sef_wet_type      o_source_wet,
  output sef_wet_type      o_sink_wet,
  output logic             o_scan_restart
);

  // Register state
  logic [31:0] config_reg, next_config_reg;
  logic [31:0] irq_en_lo, next_irq_en_lo;
  logic [15:0] irq_en_hi, next_irq_en_hi;
  logic [5:0]  wetting, next_wetting;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready;
  logic        pslverr, next_pslverr;

  // Detection state
  logic [23:0] dflt, next_dflt;
  logic [47:0] filt_cnt, next_filt_cnt;
  logic        first_cycle, next_first_cycle;
  logic        run_q, next_run_q;
  logic        ssc_evt;

  // Temperature and status
  logic        warn_q, next_warn_q;
  logic        shut_q, next_shut_q;
  logic [3:0]  int_stat, next_int_stat;
  logic        int_oe, next_int_oe;
  sef_wet_type src_wet, next_src_wet;
  sef_wet_type snk_wet, next_snk_wet;
  logic        restart, next_restart;

  // Serial state
  // Pins pass two flops to settle; the third flop finds the edges
  logic [2:0]  sclk_s, next_sclk_s;
  logic [2:0]  cs_s, next_cs_s;
  logic [1:0]  mosi_s, next_mosi_s;
  logic [32:0] rx_sh, next_rx_sh;
  logic [32:0] tx_sh, next_tx_sh;
  logic [5:0]  bit_cnt, next_bit_cnt;
  logic        miso, next_miso;
  logic        par_evt, ist_clr;

  // Access edge; a raised pready blocks a second take of one request
  wire logic   apb_acc = i_psel & i_penable & ~pready;
  wire logic   run = config_reg[`SEF_CFG_RUN];
  wire logic [1:0] filt = config_reg[`SEF_CFG_FILT_LSB +: 2];

  // APB: answer in the second access cycle, so outputs come from flops
  always_comb begin
    next_config_reg = config_reg;
    next_irq_en_lo  = irq_en_lo;
    next_irq_en_hi  = irq_en_hi;
    next_wetting    = wetting;
    next_prdata     = prdata;
    next_pready     = apb_acc;
    next_pslverr    = 1'b0;
    if (apb_acc) begin
      next_prdata = 32'h0000_0000;
      case (i_paddr)
        `SEF_ADDR_CONFIG: begin
          next_prdata = config_reg;
          if (i_pwrite) begin
            next_config_reg = i_pwdata & `SEF_CFG_MASK;
          end
        end
        `SEF_ADDR_IRQ_EN_LO: begin
          next_prdata = irq_en_lo;
          if (i_pwrite) begin
            next_irq_en_lo = i_pwdata;
          end
        end
        `SEF_ADDR_IRQ_EN_HI: begin
          next_prdata = {16'h0000, irq_en_hi};
          if (i_pwrite) begin
            next_irq_en_hi = i_pwdata[15:0];
          end
        end
        `SEF_ADDR_WETTING: begin
          next_prdata = {26'h0, wetting};
          if (i_pwrite) begin
            next_wetting = i_pwdata[5:0];
          end
        end
        `SEF_ADDR_INT_STAT: next_prdata = {28'h0000000, int_stat};
        `SEF_ADDR_SW_STAT:  next_prdata = {8'h00, dflt};
        `SEF_ADDR_MISC_STAT: next_prdata = {30'h0, shut_q, warn_q};
        // Unmapped offsets answer with an error, read as zero, write nothing
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // Register file; enables clear at reset so no input interrupts
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      config_reg <= `SEF_RST_REG;
      irq_en_lo  <= `SEF_RST_REG;
      irq_en_hi  <= 16'h0000;
      wetting    <= 6'h00;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      config_reg <= next_config_reg;
      irq_en_lo  <= next_irq_en_lo;
      irq_en_hi  <= next_irq_en_hi;
      wetting    <= next_wetting;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
    end
  end

  // Detection: edge condition and consecutive-cycle filter per input
  always_comb begin
    logic [1:0]   cnt;
    logic         chg;
    sef_edge_type mode;
    cnt = 2'h0;
    chg = 1'b0;
    mode = SEF_EDGE_OFF;
    next_dflt        = dflt;
    next_filt_cnt    = filt_cnt;
    next_first_cycle = first_cycle;
    next_run_q       = run;
    ssc_evt          = 1'b0;
    if (run && !run_q) begin
      next_first_cycle = 1'b1;
    end
    if (!run) begin
      next_filt_cnt = 48'h0;
    end else if (shut_q && !i_shut_level) begin
      next_first_cycle = 1'b1;
      next_filt_cnt    = 48'h0;
    end else if (i_cycle_done && !shut_q) begin
      // First cycle after a start or a shutdown seeds the defaults and raises SSC
      if (first_cycle) begin
        next_dflt        = i_comp_above;
        next_first_cycle = 1'b0;
        ssc_evt          = 1'b1;
      end else begin
        for (int i = 0; i < `SEF_NUM_IN; i++) begin
          cnt = filt_cnt[2*i +: 2];
          mode = (i < 16) ? sef_edge_type'(irq_en_lo[2*i +: 2])
                          : sef_edge_type'(irq_en_hi[2*(i-16) +: 2]);
          // A return to the stored status restarts the count
          if (i_comp_above[i] == dflt[i]) begin
            next_filt_cnt[2*i +: 2] = 2'h0;
          end else if (cnt >= filt) begin
            next_dflt[i] = i_comp_above[i];
            next_filt_cnt[2*i +: 2] = 2'h0;
            // Edge mode gates only the interrupt; the status moves anyway
            case (mode)
              SEF_EDGE_RISE: chg = i_comp_above[i];
              SEF_EDGE_FALL: chg = ~i_comp_above[i];
              SEF_EDGE_BOTH: chg = 1'b1;
              default:       chg = 1'b0;
            endcase
            ssc_evt = ssc_evt | chg;
          end else begin
            next_filt_cnt[2*i +: 2] = cnt + 2'h1;
          end
        end
      end
    end
  end

  // Detection registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dflt        <= 24'h000000;
      filt_cnt    <= 48'h0;
      first_cycle <= 1'b0;
      run_q       <= 1'b0;
    end else begin
      dflt        <= next_dflt;
      filt_cnt    <= next_filt_cnt;
      first_cycle <= next_first_cycle;
      run_q       <= next_run_q;
    end
  end

  // Temperature edges, interrupt status and wetting derate
  always_comb begin
    logic [3:0] set;
    logic       derate;
    set = 4'h0;
    derate = 1'b0;
    next_warn_q  = i_warn_level | i_shut_level;
    next_shut_q  = i_shut_level;
    next_restart = shut_q & ~i_shut_level;
    set[`SEF_IST_SSC]  = ssc_evt;
    set[`SEF_IST_WARN] = next_warn_q ^ warn_q;
    set[`SEF_IST_SHUT] = i_shut_level ^ shut_q;
    set[`SEF_IST_PAR]  = par_evt;
    // A fresh event in the clearing cycle survives
    next_int_stat = (ist_clr ? 4'h0 : int_stat) | set;
    next_int_oe   = |next_int_stat;
    derate = next_warn_q;
    next_src_wet = sef_wet_type'(wetting[`SEF_WET_SRC_LSB +: 3]);
    next_snk_wet = sef_wet_type'(wetting[`SEF_WET_SNK_LSB +: 3]);
    // Derate only the high settings; low ones stay as programmed
    if (derate && !config_reg[`SEF_CFG_SRC_DIS] &&
        (next_src_wet == SEF_WET_10MA || next_src_wet == SEF_WET_15MA)) begin
      next_src_wet = SEF_WET_2MA;
    end
    if (derate && !config_reg[`SEF_CFG_SNK_DIS] &&
        (next_snk_wet == SEF_WET_10MA || next_snk_wet == SEF_WET_15MA)) begin
      next_snk_wet = SEF_WET_2MA;
    end
    // Shutdown and a stopped scan cut every source and sink
    if (i_shut_level || !run) begin
      next_src_wet = SEF_WET_0MA;
      next_snk_wet = SEF_WET_0MA;
    end
  end

  // Status registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warn_q   <= 1'b0;
      shut_q   <= 1'b0;
      int_stat <= 4'h0;
      int_oe   <= 1'b0;
      src_wet  <= SEF_WET_0MA;
      snk_wet  <= SEF_WET_0MA;
      restart  <= 1'b0;
    end else begin
      warn_q   <= next_warn_q;
      shut_q   <= next_shut_q;
      int_stat <= next_int_stat;
      int_oe   <= next_int_oe;
      src_wet  <= next_src_wet;
      snk_wet  <= next_snk_wet;
      restart  <= next_restart;
    end
  end

  // Serial link, mode 0, sampled by the core clock; stays alive in shutdown
  always_comb begin
    logic [31:0] word;
    word = 32'h0;
    next_sclk_s  = {sclk_s[1:0], i_sclk};
    next_cs_s    = {cs_s[1:0], i_cs_b};
    next_mosi_s  = {mosi_s[0], i_mosi};
    next_rx_sh   = rx_sh;
    next_tx_sh   = tx_sh;
    next_bit_cnt = bit_cnt;
    next_miso    = miso;
    par_evt      = 1'b0;
    ist_clr      = 1'b0;
    if (cs_s[2] && !cs_s[1]) begin
      // Frame start: flags on top, switch statuses below
      word = {int_stat[`SEF_IST_PAR], warn_q | shut_q,
              int_stat[`SEF_IST_SSC], 5'h00, dflt};
      next_tx_sh   = {word, ~^word};
      next_miso    = word[31];
      next_bit_cnt = 6'h00;
    end else if (!cs_s[1]) begin
      // Take the bit on the rise; the commander moves it on the fall
      if (!sclk_s[2] && sclk_s[1]) begin
        next_rx_sh = {rx_sh[31:0], mosi_s[1]};
        // Saturate far past a frame, so an overlong frame never matches
        if (!(&bit_cnt)) begin
          next_bit_cnt = bit_cnt + 6'h01;
        end
      end else if (sclk_s[2] && !sclk_s[1]) begin
        // Shift on the fall, half a period before the commander samples
        next_tx_sh = {tx_sh[31:0], 1'b0};
        next_miso  = tx_sh[31];
      end
    end
    // Frame end: only an exact full frame is acted upon
    if (!cs_s[2] && cs_s[1] && bit_cnt == `SEF_SPI_BITS) begin
      if (!(^rx_sh)) begin
        par_evt = 1'b1;
      end else if (!rx_sh[`SEF_SPI_WRITE + 1] &&
                   rx_sh[`SEF_SPI_ADDR_HI+1:`SEF_SPI_ADDR_LO+1] ==
                   `SEF_SPI_IST_ADDR) begin
        ist_clr = 1'b1;
      end
    end
  end

  // Serial registers; pin inputs pass two flops before use
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s  <= 3'h0;
      cs_s    <= 3'h7;
      mosi_s  <= 2'h0;
      rx_sh   <= 33'h0;
      tx_sh   <= 33'h0;
      bit_cnt <= 6'h00;
      miso    <= 1'b0;
    end else begin
      sclk_s  <= next_sclk_s;
      cs_s    <= next_cs_s;
      mosi_s  <= next_mosi_s;
      rx_sh   <= next_rx_sh;
      tx_sh   <= next_tx_sh;
      bit_cnt <= next_bit_cnt;
      miso    <= next_miso;
    end
  end

  // Outputs straight from flops
  assign o_prdata       = prdata;
  assign o_pready       = pready;
  assign o_pslverr      = pslverr;
  assign o_miso         = miso;
  // Open drain: the pin is only pulled low, so the enable is the level
  assign o_int_b_out    = 1'b0;
  assign o_int_b_oe     = int_oe;
  assign o_source_wet   = src_wet;
  assign o_sink_wet     = snk_wet;
  assign o_scan_restart = restart;

endmodule

// ===== test/sef_event_flags_props.sv
`timescale 1ns/1ps
module sef_event_flags_props
  import sef_pkg::*;
(
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  // Register bus
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Temperature, select, interrupt and drive
  input wire logic        i_warn_level,
  input wire logic        i_shut_level,
  input wire logic        i_cs_b,
  input wire logic        o_int_b_oe,
  input wire sef_wet_type o_source_wet,
  input wire sef_wet_type o_sink_wet,
  input wire logic        o_scan_restart
);
  // One domain, so one clock and one reset for all
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // Bus answers one cycle after the access edge, even in shutdown
  property p_bus_answer;
    i_psel && i_penable && !o_pready |=> o_pready;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");
  property p_ready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_err_zero;
    o_pslverr |-> o_pready && o_prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero)
    else $error("error answer malformed");
  // Shutdown cuts every source and sink
  property p_shut_cut;
    i_shut_level [*3] |-> o_source_wet == SEF_WET_0MA
      && o_sink_wet == SEF_WET_0MA;
  endproperty
  a_shut_cut: assert property (p_shut_cut)
    else $error("current flows in shutdown");
  // Entry and exit of shut, and of warn while shut is low, pull the pin
  property p_temp_irq;
    $changed(i_warn_level) || $changed(i_shut_level)
      |-> ##[1:3] o_int_b_oe;
  endproperty
  a_temp_irq: assert property (p_temp_irq)
    else $error("no interrupt on temperature change");
  property p_restart;
    $fell(i_shut_level) |-> ##[1:3] o_scan_restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("scan not restarted");
  property p_restart_pulse;
    o_scan_restart |-> !i_shut_level ##1 !o_scan_restart;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("restart pulse malformed");
  // Pin is released only once the select has gone high
  property p_release;
    $fell(o_int_b_oe) |-> i_cs_b;
  endproperty
  a_release: assert property (p_release)
    else $error("interrupt released inside a frame");
endmodule

// ===== test/sef_spi_cmd.sv
`timescale 1ns/1ps
module sef_spi_cmd (
  // Serial pins toward the block
  output logic      o_sclk,
  output logic      o_cs_b,
  output logic      o_mosi,
  input  wire logic i_miso
);
  // Clock stands low outside frames
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b0;
  end
  // One 33-bit mode 0 frame, MSB first; flip spoils the parity
  task automatic xfer(input logic [31:0] w, input logic flip,
                      output logic [32:0] r);
    logic [32:0] f;
    f = {w, ~^w ^ flip};
    #17 o_cs_b = 1'b0;
    for (int i = 32; i >= 0; i--) begin
      o_mosi = f[i];
      #200 o_sclk = 1'b1;
      r[i] = i_miso;
      #200 o_sclk = 1'b0;
    end
    #200 o_cs_b = 1'b1;
    o_mosi = ~o_mosi; // Released line keeps no stale bit
    #800;
  endtask
endmodule

// ===== test/sef_event_flags_test.sv
`timescale 1ns/1ps
module sef_event_flags_test;
  import sef_pkg::*;
  // Design pins
  logic        i_core_clk;
  logic        i_rst_b;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic [23:0] i_comp_above;
  logic        i_cycle_done;
  logic        i_warn_level;
  logic        i_shut_level;
  logic        i_sclk;
  logic        i_cs_b;
  logic        i_mosi;
  logic        o_miso;
  logic        o_int_b_out;
  logic        o_int_b_oe;
  sef_wet_type o_source_wet;
  sef_wet_type o_sink_wet;
  logic        o_scan_restart;
  // Bench state
  int          err_count;
  int          n_tests;
  logic [31:0] rdat;
  logic        rerr;
  logic [32:0] sw;
  // Edge table: input 0 rise, 1 fall, 2 both, 3 off, 16 rise
  localparam logic [191:0] EDGE_V = {24'h01000a, 24'h00000a, 24'h000002,
    24'h000006, 24'h000002, 24'h000000, 24'h000002, 24'h000003};
  localparam logic [7:0]   EDGE_I = 8'b1011_0101;

  sef_event_flags u_sef_event_flags (.i_core_clk, .i_rst_b, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr, .i_comp_above, .i_cycle_done, .i_warn_level,
    .i_shut_level, .i_sclk, .i_cs_b, .i_mosi, .o_miso, .o_int_b_out,
    .o_int_b_oe, .o_source_wet, .o_sink_wet, .o_scan_restart);
  sef_spi_cmd u_sef_spi_cmd (.o_sclk(i_sclk), .o_cs_b(i_cs_b),
    .o_mosi(i_mosi), .i_miso(o_miso));

  task automatic tally_and_finish();
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request holds until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      tally_and_finish();
    end
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wchk(input sef_wet_type s, input sef_wet_type k);
    chk({26'h0, o_sink_wet, o_source_wet}, {26'h0, k, s});
  endtask
  task automatic ochk(input logic e);
    chk({31'h0, o_int_b_oe}, {31'h0, e});
  endtask
  // Serial read of interrupt status, which clears it at select rise
  task automatic spi_clear();
    u_sef_spi_cmd.xfer(32'h0400_0000, 1'b0, sw);
    chk({31'h0, ^sw}, 32'h1);
  endtask
  task automatic strobe(input logic [23:0] v);
    @(posedge i_core_clk);
    i_comp_above <= v;
    i_cycle_done <= 1'b1;
    @(posedge i_core_clk);
    i_cycle_done <= 1'b0;
    repeat (3) @(posedge i_core_clk);
  endtask
  task automatic temp(input logic w, input logic s);
    @(posedge i_core_clk);
    i_warn_level <= w;
    i_shut_level <= s;
    repeat (4) @(posedge i_core_clk);
  endtask

  // Reset values, with 1c the unmapped hole
  task automatic t_reset();
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      chk({31'h0, rerr}, {31'h0, a == 28});
      chk(rdat, 32'h0);
    end
    ochk(1'b0);
    chk({31'h0, o_int_b_out}, 32'h0);
  endtask
  task automatic t_first();
    apb(1'b1, 8'h04, 32'h0000_0039);
    apb(1'b1, 8'h08, 32'h0000_0001);
    strobe(24'h000002);
    rchk(8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    strobe(24'h000002);
    rchk(8'h10, 32'h1);
    rchk(8'h14, 32'h2);
    ochk(1'b1);
    spi_clear();
    chk({31'h0, sw[30]}, 32'h1);
    rchk(8'h10, 32'h0);
    ochk(1'b0);
  endtask
  task automatic t_edges();
    for (int k = 0; k < 8; k++) begin
      strobe(EDGE_V[k*24 +: 24]);
      rchk(8'h10, {31'h0, EDGE_I[k]});
      rchk(8'h14, {8'h0, EDGE_V[k*24 +: 24]});
      spi_clear();
    end
  endtask
  // Four stable cycles needed before input 0 reports
  task automatic t_filter();
    apb(1'b1, 8'h00, 32'h7);
    for (int k = 1; k <= 4; k++) begin
      strobe(24'h01000b);
      rchk(8'h10, {31'h0, k == 4});
    end
    spi_clear();
  endtask
  // Stopping the scan drops a half-counted change; filters 1 and 2
  task automatic t_run_clear();
    apb(1'b1, 8'h00, 32'h3);
    strobe(24'h01000f);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h00, 32'h3);
    strobe(24'h01000b);
    rchk(8'h10, 32'h1);
    spi_clear();
    for (int k = 1; k <= 2; k++) begin
      strobe(24'h01000f);
      rchk(8'h10, {31'h0, k == 2});
    end
    spi_clear();
    apb(1'b1, 8'h00, 32'h5);
    for (int k = 1; k <= 3; k++) begin
      strobe(24'h01000b);
      rchk(8'h10, {31'h0, k == 3});
    end
    spi_clear();
  endtask
  task automatic t_temp();
    apb(1'b1, 8'h0c, 32'h25);
    apb(1'b1, 8'h00, 32'h11);
    wchk(SEF_WET_15MA, SEF_WET_10MA);
    temp(1'b1, 1'b0);
    rchk(8'h10, 32'h2);
    wchk(SEF_WET_2MA, SEF_WET_10MA);
    spi_clear();
    chk({31'h0, sw[31]}, 32'h1);
    repeat (8) @(posedge i_core_clk);
    ochk(1'b0);
    rchk(8'h18, 32'h1);
    temp(1'b1, 1'b1);
    rchk(8'h10, 32'h4);
    rchk(8'h18, 32'h3);
    wchk(SEF_WET_0MA, SEF_WET_0MA);
    spi_clear();
    chk({8'h0, sw[24:1]}, 32'h0001_000b);
    temp(1'b1, 1'b0);
    rchk(8'h10, 32'h4);
    rchk(8'h18, 32'h1);
    spi_clear();
    strobe(24'h000000);
    rchk(8'h10, 32'h1);
    rchk(8'h14, 32'h0);
    spi_clear();
    temp(1'b0, 1'b0);
    rchk(8'h10, 32'h2);
    rchk(8'h18, 32'h0);
    wchk(SEF_WET_15MA, SEF_WET_10MA);
    spi_clear();
  endtask
  // A spoilt read is dropped, so status survives it
  task automatic t_parity();
    u_sef_spi_cmd.xfer(32'h0400_0000, 1'b1, sw);
    rchk(8'h10, 32'h8);
    ochk(1'b1);
    spi_clear();
    chk({31'h0, sw[32]}, 32'h1);
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  initial begin
    {i_rst_b, i_psel, i_penable, i_pwrite, i_cycle_done} = 5'h0;
    {i_paddr, i_pwdata, i_comp_above} = 64'h0;
    {i_warn_level, i_shut_level} = 2'h0;
    err_count = 0;
    n_tests = 0;
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_first();
    t_edges();
    t_filter();
    t_run_clear();
    t_temp();
    t_parity();
    tally_and_finish();
  end
endmodule

bind sef_event_flags sef_event_flags_props u_sef_event_flags_props (
  .i_core_clk, .i_rst_b, .i_psel, .i_penable, .o_prdata, .o_pready,
  .o_pslverr, .i_warn_level, .i_shut_level, .i_cs_b, .o_int_b_oe,
  .o_source_wet, .o_sink_wet, .o_scan_restart);
